/* shared/ptmr_pkg.sv */
// Package with register map, field layout and state types of the pulse timer.
package ptmr_pkg;
    localparam int CW = 16;
    localparam logic [3:0] A_RUN = 4'h0;
    localparam logic [3:0] A_FFCR = 4'h1;
    localparam logic [3:0] A_MOD = 4'h2;
    localparam logic [3:0] A_DUTY = 4'h3;
    localparam logic [3:0] A_PER = 4'h4;
    localparam logic [3:0] A_CAP0 = 4'h5;
    localparam logic [3:0] A_CAP1 = 4'h6;
    localparam logic [3:0] A_CNT = 4'h7;
    localparam logic [3:0] A_STAT = 4'h8;
    // Run register bits.
    localparam int RUN_CNT = 0;
    localparam int RUN_PRE = 2;
    localparam int RUN_DBUF = 7;
    // Flip-flop control bits.
    localparam int FF_SET_CLR_LO = 0;
    localparam int FF_SET_CLR_HI = 1;
    localparam int FF_T_DUTY = 2;
    localparam int FF_T_PER = 3;
    localparam int FF_T_CAP0 = 4;
    localparam int FF_POL = 6;
    localparam logic [1:0] FF_CLEAR = 2'h2;
    localparam logic [1:0] FF_SET = 2'h1;
    // Mode register fields.
    localparam int MOD_CLK_LO = 0;
    localparam int MOD_CPM_LO = 3;
    localparam int MOD_CLR = 5;
    localparam logic [1:0] CLK_EXT = 2'h0;
    localparam logic [1:0] CLK_PRE1 = 2'h1;
    localparam logic [1:0] CLK_PRE2 = 2'h2;
    localparam logic [1:0] CPM_OFF = 2'h0;
    localparam logic [1:0] CPM_TRIG_A = 2'h1;
    localparam logic [1:0] CPM_WIDTH = 2'h2;
    localparam logic [1:0] CPM_AUX = 2'h3;
    // Prescaler taps for clock-select values 1, 2 and 3.
    localparam int PRE_W = 8;
    // Taps give division by 2, 8 and 128 of the system clock.
    localparam int TAP1 = 0;
    localparam int TAP2 = 2;
    localparam int TAP3 = 6;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE = 16'h0001;
    localparam logic [CW-1:0] REG16_RST = 16'hffff;

    typedef struct packed {
        logic [3:0] addr;
        logic [CW-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic trig_a;
        logic trig_b;
        logic count_in;
        logic aux_ff;
    } pins_t;

    typedef struct packed {
        logic period_match_irq;
        logic second_match_irq;
        logic trigger_a_ext_irq;
        logic trigger_b_ext_irq;
    } irq_t;

    typedef struct packed {
        logic [1:0] s_a;
        logic [1:0] s_b;
        logic [1:0] s_c;
        logic [1:0] s_x;
        logic p_a;
        logic p_b;
        logic p_c;
        logic p_x;
        logic [7:0] run;
        logic [7:0] ffcr;
        logic [7:0] mode;
        logic [CW-1:0] duty_buf;
        logic [CW-1:0] duty;
        logic [CW-1:0] period;
        logic [CW-1:0] cap0;
        logic [CW-1:0] cap1;
        logic [CW-1:0] cnt;
        logic [PRE_W-1:0] pre;
        logic ff;
        logic pin;
        irq_t irq;
        logic [CW-1:0] rdata;
    } state_t;
endpackage

/* hw/pulse_capture_timer.sv */
// Sixteen-bit pulse generator and capture timer with a strobe register port.
//
// Operation
// R1 - Square wave with programmable period and duty; output polarity selectable.
// R2 - Flip-flop inverts on counter match with duty or period compare.
// R3 - Software keeps duty compare strictly below period compare.
// R4 - With double buffer on, buffered duty loads at period match.
// R5 - Software stops counter, loads compares, then enables buffer and starts.
// R6 - Control pattern 00111 0 enables both match toggles and clears flip-flop.
// R7 - Mode pattern 001001 with clock select 1..3 uses prescaler, no capture; code takes bits 4:3 = 01 of it as trigger A capture.
// R8 - Counter runs from prescaler; trigger A rise loads first capture.
// R9 - Trigger enable field 11 allows toggling on both compare matches.
// R10 - Period match raises interrupt; software then stops toggling.
// R11 - Flip-flop may toggle when first capture loads.
// R12 - Counter may count rising edges of external count input.
// R13 - Capture mode 11 uses aux flip-flop edges for both captures.
// R14 - Capture mode 10 uses trigger A edges; interrupt on falling edge.
// R15 - Other capture modes raise trigger A interrupt on rising edge.
// R16 - Trigger B rise loads second capture and raises its interrupt.
// R17 - Counter keeps free-running through captures, never cleared by them.
// R18 - With clear enabled, counter wraps to zero after period match.
// R19 - Software keeps prescaler running when counting external events.
// R20 - Software avoids read-modify-write on timer registers.
`timescale 1ns/1ns
module pulse_capture_timer
    import ptmr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire bus_req_t bus,
    input wire pins_t pins,
    output logic [CW-1:0] rdata,
    output logic pulse_output_pin,
    output irq_t irq
);
    state_t q;
    state_t d;
    logic tick;
    logic run;
    logic cap_a_rise;
    logic cap_a_fall;
    logic b_rise;
    logic aux_rise;
    logic aux_fall;
    logic duty_hit;
    logic per_hit;
    logic [1:0] cpm;
    logic [1:0] csel;

    assign run = q.run[RUN_CNT];
    assign cpm = q.mode[MOD_CPM_LO+1:MOD_CPM_LO];
    assign csel = q.mode[MOD_CLK_LO+1:MOD_CLK_LO];
    // Edges are taken from the second synchroniser stage and its delayed copy.
    assign cap_a_rise = q.s_a[1] & ~q.p_a;
    assign cap_a_fall = ~q.s_a[1] & q.p_a;
    assign b_rise = q.s_b[1] & ~q.p_b;
    assign aux_rise = q.s_x[1] & ~q.p_x;
    assign aux_fall = ~q.s_x[1] & q.p_x;
    assign duty_hit = run & tick & (q.cnt == q.duty);
    assign per_hit = run & tick & (q.cnt == q.period);

    // A prescaler tap pulses once per wrap of its low bits.
    always_comb begin
        case (csel)
            CLK_EXT: tick = q.s_c[1] & ~q.p_c; // R12
            CLK_PRE1: tick = &q.pre[TAP1:0]; // R7 R8
            CLK_PRE2: tick = &q.pre[TAP2:0];
            default: tick = &q.pre[TAP3:0];
        endcase
    end

    always_comb begin
        d = q;
        d.irq = '0;
        d.s_a = {q.s_a[0], pins.trig_a};
        d.s_b = {q.s_b[0], pins.trig_b};
        d.s_c = {q.s_c[0], pins.count_in};
        d.s_x = {q.s_x[0], pins.aux_ff};
        d.p_a = q.s_a[1];
        d.p_b = q.s_b[1];
        d.p_c = q.s_c[1];
        d.p_x = q.s_x[1];
        if (q.run[RUN_PRE]) begin
            d.pre = q.pre + PRE_W'(1);
        end
        if (tick && run) begin
            if (per_hit && q.mode[MOD_CLR]) begin
                d.cnt = CNT_ZERO; // R18
            end else begin
                d.cnt = q.cnt + CNT_ONE; // R17
            end
        end
        // Toggle on matches when the trigger-enable field allows it.
        if ((duty_hit && q.ffcr[FF_T_DUTY]) ^
            (per_hit && q.ffcr[FF_T_PER])) begin
            d.ff = ~q.ff; // R2 R9
        end
        if (per_hit) begin
            d.irq.period_match_irq = 1'b1; // R10
            d.irq.second_match_irq = 1'b1; // R10
            if (q.run[RUN_DBUF]) begin
                d.duty = q.duty_buf; // R4
            end
        end
        // Captures sample the counter value seen in this same cycle.
        case (cpm)
            CPM_TRIG_A: begin
                if (cap_a_rise) begin
                    d.cap0 = q.cnt; // R8
                    if (q.ffcr[FF_T_CAP0]) begin
                        d.ff = ~d.ff; // R11
                    end
                end
            end
            CPM_WIDTH: begin
                if (cap_a_rise) begin
                    d.cap0 = q.cnt; // R14
                    if (q.ffcr[FF_T_CAP0]) begin
                        d.ff = ~d.ff; // R11
                    end
                end
                if (cap_a_fall) begin
                    d.cap1 = q.cnt; // R14
                end
            end
            CPM_AUX: begin
                if (aux_rise) begin
                    d.cap0 = q.cnt; // R13
                end
                if (aux_fall) begin
                    d.cap1 = q.cnt; // R13
                end
            end
            default: begin
            end
        endcase
        if (cpm == CPM_WIDTH) begin
            d.irq.trigger_a_ext_irq = cap_a_fall; // R14
        end else begin
            d.irq.trigger_a_ext_irq = cap_a_rise; // R15
        end
        if (b_rise) begin
            d.irq.trigger_b_ext_irq = 1'b1; // R16
            if (cpm != CPM_OFF) begin
                d.cap1 = q.cnt; // R16
            end
        end
        d.rdata = '0;
        if (bus.wr) begin
            if (bus.addr == A_RUN) begin
                d.run = bus.wdata[7:0];
            end else if (bus.addr == A_FFCR) begin
                d.ffcr = bus.wdata[7:0];
                // Direct set or clear of the flip-flop wins over a match.
                if (bus.wdata[FF_SET_CLR_HI:FF_SET_CLR_LO] == FF_CLEAR) begin
                    d.ff = 1'b0; // R6
                end else if (bus.wdata[FF_SET_CLR_HI:FF_SET_CLR_LO] == FF_SET)
                begin
                    d.ff = 1'b1;
                end
            end else if (bus.addr == A_MOD) begin
                d.mode = bus.wdata[7:0]; // R7
            end else if (bus.addr == A_DUTY) begin
                d.duty_buf = bus.wdata;
                if (!q.run[RUN_DBUF]) begin
                    d.duty = bus.wdata;
                end
            end else if (bus.addr == A_PER) begin
                d.period = bus.wdata;
            end
        end
        if (bus.rd) begin
            if (bus.addr == A_RUN) begin
                d.rdata = {8'h00, q.run};
            end else if (bus.addr == A_FFCR) begin
                d.rdata = {8'h00, q.ffcr};
            end else if (bus.addr == A_MOD) begin
                d.rdata = {8'h00, q.mode};
            end else if (bus.addr == A_DUTY) begin
                d.rdata = q.duty;
            end else if (bus.addr == A_PER) begin
                d.rdata = q.period;
            end else if (bus.addr == A_CAP0) begin
                d.rdata = q.cap0;
            end else if (bus.addr == A_CAP1) begin
                d.rdata = q.cap1;
            end else if (bus.addr == A_CNT) begin
                d.rdata = q.cnt;
            end else if (bus.addr == A_STAT) begin
                d.rdata = {15'h0000, q.ff};
            end
        end
        // Polarity bit inverts the pin so either active level can be used.
        d.pin = d.ff ^ d.ffcr[FF_POL]; // R1
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.duty <= REG16_RST;
            q.duty_buf <= REG16_RST;
            q.period <= REG16_RST;
            q.mode <= REG8_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign pulse_output_pin = q.pin;
    assign irq = q.irq;

    chk_period_irq_pulse: assert property (@(posedge clk) disable iff (!nrst)
        per_hit |=> irq.period_match_irq) // R10
        else $error("period match did not raise interrupt");
    chk_dbuf_load: assert property (@(posedge clk) disable iff (!nrst)
        per_hit && q.run[RUN_DBUF] |=> q.duty == $past(q.duty_buf)) // R4
        else $error("duty buffer not transferred at period match");
    chk_counter_clear: assert property (@(posedge clk) disable iff (!nrst)
        per_hit && q.mode[MOD_CLR] |=> q.cnt == CNT_ZERO) // R18
        else $error("counter not cleared after period match");
    chk_cap0_value: assert property (@(posedge clk) disable iff (!nrst)
        cap_a_rise && cpm == CPM_TRIG_A |=> q.cap0 == $past(q.cnt)) // R8
        else $error("first capture missed trigger rise");
    chk_width_fall_irq: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_WIDTH && cap_a_fall |=> irq.trigger_a_ext_irq) // R14
        else $error("width mode interrupt not on falling edge");
    chk_rise_irq: assert property (@(posedge clk) disable iff (!nrst)
        cpm != CPM_WIDTH && cap_a_rise |=> irq.trigger_a_ext_irq) // R15
        else $error("trigger interrupt not on rising edge");
    chk_aux_cap1: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_AUX && aux_fall |=> q.cap1 == $past(q.cnt)) // R13
        else $error("second capture missed aux falling edge");
    chk_b_irq: assert property (@(posedge clk) disable iff (!nrst)
        b_rise |=> irq.trigger_b_ext_irq) // R16
        else $error("trigger b interrupt missing");
    chk_ff_clear: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && bus.addr == A_FFCR &&
        bus.wdata[FF_SET_CLR_HI:FF_SET_CLR_LO] == FF_CLEAR
        |=> !q.ff) // R6
        else $error("flip-flop not cleared by control write");
    chk_pin_polarity: assert property (@(posedge clk) disable iff (!nrst)
        pulse_output_pin == (q.ff ^ q.ffcr[FF_POL])) // R1 R2
        else $error("output pin disagrees with flip-flop");

    // Multi-step behaviours are built from these named sequences.
    sequence s_period_hit;
        per_hit;
    endsequence

    sequence s_both_match_irqs;
        irq.period_match_irq && irq.second_match_irq;
    endsequence

    sequence s_ff_left_alone;
        !(bus.wr && bus.addr == A_FFCR) && !cap_a_rise;
    endsequence

    sequence s_ff_set_write;
        bus.wr && bus.addr == A_FFCR &&
        bus.wdata[FF_SET_CLR_HI:FF_SET_CLR_LO] == FF_SET;
    endsequence

    chk_both_match_irqs: assert property (@(posedge clk) disable iff (!nrst)
        s_period_hit |=> s_both_match_irqs) // R10
        else $error("match interrupts not raised together");

    chk_irqs_paired: assert property (@(posedge clk) disable iff (!nrst)
        irq.period_match_irq == irq.second_match_irq) // R10
        else $error("match interrupts differ");

    chk_irq_single: assert property (@(posedge clk) disable iff (!nrst)
        irq.period_match_irq |=> !irq.period_match_irq) // R10
        else $error("period interrupt longer than one cycle");

    chk_duty_toggle: assert property (@(posedge clk) disable iff (!nrst)
        (duty_hit && !per_hit && q.ffcr[FF_T_DUTY]) ##0 s_ff_left_alone
        |=> q.ff != $past(q.ff)) // R2 R9
        else $error("flip-flop did not toggle on duty match");

    chk_per_toggle: assert property (@(posedge clk) disable iff (!nrst)
        (per_hit && !duty_hit && q.ffcr[FF_T_PER]) ##0 s_ff_left_alone
        |=> q.ff != $past(q.ff)) // R2 R9
        else $error("flip-flop did not toggle on period match");

    chk_ff_hold: assert property (@(posedge clk) disable iff (!nrst)
        (!duty_hit && !per_hit) ##0 s_ff_left_alone
        |=> $stable(q.ff)) // R2
        else $error("flip-flop changed without a cause");

    chk_cap_toggle: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_TRIG_A && cap_a_rise && q.ffcr[FF_T_CAP0] &&
        !duty_hit && !per_hit && !(bus.wr && bus.addr == A_FFCR)
        |=> q.ff != $past(q.ff)) // R11
        else $error("flip-flop did not toggle on capture");

    chk_ff_set: assert property (@(posedge clk) disable iff (!nrst)
        s_ff_set_write |=> q.ff) // R6
        else $error("flip-flop not set by control write");

    chk_dbuf_hold: assert property (@(posedge clk) disable iff (!nrst)
        !per_hit && q.run[RUN_DBUF] && !(bus.wr && bus.addr == A_DUTY)
        |=> $stable(q.duty)) // R4
        else $error("active duty changed between period matches");

    chk_cnt_step: assert property (@(posedge clk) disable iff (!nrst)
        tick && run && !per_hit |=> q.cnt == $past(q.cnt) + CNT_ONE) // R17
        else $error("counter did not step on a tick");

    chk_cnt_idle: assert property (@(posedge clk) disable iff (!nrst)
        !(tick && run) |=> $stable(q.cnt)) // R12
        else $error("counter moved without a tick");

    chk_pre_hold: assert property (@(posedge clk) disable iff (!nrst)
        !q.run[RUN_PRE] |=> $stable(q.pre)) // R19
        else $error("prescaler ran while stopped");

    chk_cap_off: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_OFF |=> $stable(q.cap0) && $stable(q.cap1)) // R7
        else $error("capture happened with capture disabled");

    chk_width_cap1: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_WIDTH && cap_a_fall |=> q.cap1 == $past(q.cnt)) // R14
        else $error("second capture missed falling edge");

    chk_width_rise_quiet: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_WIDTH && !cap_a_fall |=> !irq.trigger_a_ext_irq) // R14
        else $error("width mode interrupt without falling edge");

    chk_aux_cap0: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_AUX && aux_rise |=> q.cap0 == $past(q.cnt)) // R13
        else $error("first capture missed aux rising edge");

    chk_b_cap1: assert property (@(posedge clk) disable iff (!nrst)
        cpm == CPM_TRIG_A && b_rise |=> q.cap1 == $past(q.cnt)) // R16
        else $error("second capture missed trigger b rise");

    chk_b_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !b_rise |=> !irq.trigger_b_ext_irq) // R16
        else $error("trigger b interrupt without an edge");

    // Read data must stand only in the cycle after the strobe.
    chk_read_count: assert property (@(posedge clk) disable iff (!nrst)
        bus.rd && bus.addr == A_CNT |=> rdata == $past(q.cnt))
        else $error("count read returned a wrong value");

    chk_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
        !bus.rd |=> rdata == CNT_ZERO)
        else $error("read data not zero outside a read");
endmodule

/* test/pin_driver.sv */
// Far-side model that drives the trigger, count and aux flip-flop pins.
`timescale 1ns/1ns
module pin_driver
    import ptmr_pkg::*;
(
    input wire logic clk,
    output pins_t pins
);
    initial begin
        pins = '0;
    end
    // Each level is held six cycles, so the two-flop sync sees every edge.
    task automatic hold();
        repeat (6) @(posedge clk);
    endtask
    task automatic count(input int n);
        for (int i = 0; i < n; i++) begin
            pins.count_in <= 1'b1;
            hold();
            pins.count_in <= 1'b0;
            hold();
        end
    endtask
    task automatic trig(input int sel, input logic v);
        case (sel)
            0: pins.trig_a <= v;
            1: pins.trig_b <= v;
            default: pins.aux_ff <= v;
        endcase
        hold();
    endtask
endmodule

/* test/pulse_capture_timer_bench.sv */
// Self-checking bench for the pulse generator and capture timer.
`timescale 1ns/1ns
module pulse_capture_timer_bench;
    import ptmr_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    bus_req_t bus = '0;
    pins_t pins;
    logic [CW-1:0] rdata;
    logic pulse_output_pin;
    irq_t irq;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_per = 0;
    int n_a = 0;
    int n_b = 0;
    int n_sec = 0;
    always #10 clk = ~clk;
    pulse_capture_timer i_pulse_capture_timer (
        .clk(clk),
        .nrst(nrst),
        .bus(bus),
        .pins(pins),
        .rdata(rdata),
        .pulse_output_pin(pulse_output_pin),
        .irq(irq)
    );
    pin_driver i_pin_driver (
        .clk(clk),
        .pins(pins)
    );
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Interrupts stand one cycle only, so they are tallied at every edge.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq.period_match_irq === 1'b1) n_per++;
        if (irq.second_match_irq === 1'b1) n_sec++;
        if (irq.trigger_a_ext_irq === 1'b1) n_a++;
        if (irq.trigger_b_ext_irq === 1'b1) n_b++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [CW-1:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [CW-1:0] exp);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
        check(rdata, exp);
    endtask
    task automatic pin(input logic exp);
        check({15'h0000, pulse_output_pin}, {15'h0000, exp});
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        n_per = 0;
        n_a = 0;
        n_b = 0;
        n_sec = 0;
        @(posedge clk);
    endtask
    task automatic t_reset();
        rd(A_DUTY, 16'hffff);
        rd(A_PER, 16'hffff);
        rd(A_CAP0, 16'h0000);
        rd(A_CNT, 16'h0000);
        rd(4'h9, 16'h0000);
        pin(1'b0);
        $display("t_reset done");
    endtask
    task automatic t_ppg();
        wr(A_RUN, 16'h0000);
        wr(A_DUTY, 16'h0003);
        wr(A_PER, 16'h0007);
        wr(A_RUN, 16'h0080);
        wr(A_FFCR, 16'h000e);
        wr(A_MOD, 16'h0020);
        wr(A_RUN, 16'h0085);
        i_pin_driver.count(4);
        pin(1'b1);
        i_pin_driver.count(4);
        pin(1'b0);
        check(16'(n_per), 16'h0001);
        check(16'(n_sec), 16'h0001);
        rd(A_CNT, 16'h0000);
        wr(A_DUTY, 16'h0005);
        i_pin_driver.count(4);
        pin(1'b1);
        i_pin_driver.count(4);
        pin(1'b0);
        i_pin_driver.count(5);
        pin(1'b0);
        i_pin_driver.count(1);
        pin(1'b1);
        wr(A_FFCR, 16'h004e);
        pin(1'b1);
        $display("t_ppg done");
    endtask
    task automatic t_cap();
        do_reset();
        wr(A_MOD, 16'h0008);
        wr(A_FFCR, 16'h0012);
        wr(A_RUN, 16'h0005);
        i_pin_driver.count(4);
        i_pin_driver.trig(0, 1'b1);
        rd(A_CAP0, 16'h0004);
        check(16'(n_a), 16'h0001);
        pin(1'b1);
        i_pin_driver.trig(0, 1'b0);
        i_pin_driver.trig(1, 1'b1);
        rd(A_CAP1, 16'h0004);
        check(16'(n_b), 16'h0001);
        i_pin_driver.trig(1, 1'b0);
        wr(A_MOD, 16'h0010);
        i_pin_driver.count(2);
        i_pin_driver.trig(0, 1'b1);
        rd(A_CAP0, 16'h0006);
        check(16'(n_a), 16'h0001);
        i_pin_driver.count(3);
        i_pin_driver.trig(0, 1'b0);
        rd(A_CAP1, 16'h0009);
        check(16'(n_a), 16'h0002);
        wr(A_MOD, 16'h0018);
        i_pin_driver.trig(2, 1'b1);
        rd(A_CAP0, 16'h0009);
        i_pin_driver.count(1);
        i_pin_driver.trig(2, 1'b0);
        rd(A_CAP1, 16'h000a);
        rd(A_CNT, 16'h000a);
        wr(A_MOD, 16'h0025);
        i_pin_driver.trig(0, 1'b1);
        rd(A_CAP0, 16'h0009);
        check(16'(n_a), 16'h0003);
        $display("t_cap done");
    endtask
    initial begin
        do_reset();
        t_reset();
        t_ppg();
        t_cap();
        conclude();
    end
endmodule
